// ---- pkg/sfrdec_pkg.sv ----
package sfrdec_pkg;
  // Special register addresses
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] XRAM_MAP_CONFIG_ADDR = 8'h85;
  localparam logic [7:0] XRAM_PAGE_SELECT_ADDR = 8'hAA;
  // Configuration register layout
  localparam int WINDOW_EN_BIT = 6;
  localparam logic [7:0] XRAM_MAP_CONFIG_RESET = 8'h03;
  localparam logic [5:0] CONFIG_FIXED_LOW = 6'h03;
  localparam logic [2:0] PAGE_FIELD_RESET = 3'h0;
  // External data space
  localparam logic [15:0] WINDOW_LO = 16'h0400;
  localparam logic [15:0] WINDOW_HI = 16'h04FF;
  localparam int XRAM_ADDR_W = 10;
  // Core-clock wait cycles for a buffer access (crosses to the usb side) and for a normal RAM access
  localparam logic [2:0] BUFFER_WAIT_CYCLES = 3'h4;
  localparam logic [2:0] XRAM_WAIT_CYCLES = 3'h1;
  typedef enum logic [2:0] {
    SFRDEC_IDLE = 3'b001,
    SFRDEC_WAIT = 3'b010,
    SFRDEC_DONE = 3'b100
  } sfrdec_state_e;
endpackage

// ---- verilog/sfrdec_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module sfrdec_top (
  input wire logic ref_clk,
  input wire logic rst_b,
  // Direct-address access from the core
  input wire logic dir_req,
  input wire logic dir_we,
  input wire logic dir_bit_op,
  input wire logic [7:0] dir_addr,
  input wire logic [7:0] dir_wdata,
  input wire logic dir_bit_wval,
  output logic [7:0] dir_rdata,
  output logic dir_bit_rval,
  output logic dir_sfr_sel,
  output logic dir_bit_ok,
  output logic [7:0] sfr_byte_addr,
  // External-move access from the core
  input wire logic xmov_req,
  input wire logic xmov_we,
  input wire logic xmov_short,
  input wire logic [15:0] xmov_addr,
  // Routed external-move target
  output logic xram_sel,
  output logic buf_sel,
  output logic [9:0] xram_addr,
  output logic [7:0] buf_addr,
  output logic xmov_we_out,
  output logic xmov_ready,
  output logic buffer_window_enable,
  output logic [2:0] page_field
);
  logic next_window_en;
  logic [2:0] next_page;
  logic [7:0] next_rdata;
  logic next_bit_rval;
  logic next_sfr_sel;
  logic next_bit_ok;
  logic [7:0] next_byte_addr;
  logic [7:0] tgt;
  logic [7:0] cur;
  logic [7:0] wval;
  logic hit;

  // Bit-addressable registers sit at low nibble 0x0 or 0x8
  function automatic logic bit_capable(input logic [7:0] a);
    return a[2:0] == 3'h0;
  endfunction

  function automatic logic [7:0] reg_view(input logic [7:0] a,
                                          input logic en,
                                          input logic [2:0] pg);
    if (a == sfrdec_pkg::XRAM_MAP_CONFIG_ADDR) begin
      return {1'b0, en, sfrdec_pkg::CONFIG_FIXED_LOW};
    end else if (a == sfrdec_pkg::XRAM_PAGE_SELECT_ADDR) begin
      return {5'h00, pg};
    end
    // Unoccupied addresses read zero and swallow writes
    return 8'h00;
  endfunction

  always_comb begin
    next_window_en = buffer_window_enable;
    next_page = page_field;
    next_rdata = dir_rdata;
    next_bit_rval = dir_bit_rval;
    next_sfr_sel = 1'b0;
    next_bit_ok = 1'b0;
    next_byte_addr = sfr_byte_addr;
    tgt = dir_bit_op ? {dir_addr[7:3], 3'h0} : dir_addr;
    cur = reg_view(tgt, buffer_window_enable, page_field);
    wval = cur;
    // Bit ops only reach the upper half through bit-capable registers
    hit = dir_req && dir_addr >= sfrdec_pkg::SFR_BASE &&
          (!dir_bit_op || bit_capable(tgt));
    if (hit) begin
      next_sfr_sel = 1'b1;
      next_bit_ok = dir_bit_op;
      next_byte_addr = tgt;
      next_rdata = cur;
      next_bit_rval = cur[dir_addr[2:0]];
      if (dir_bit_op) begin
        wval[dir_addr[2:0]] = dir_bit_wval;
      end else begin
        wval = dir_wdata;
      end
      if (dir_we) begin
        // Read-modify-write keeps fixed bits; only live fields stored
        if (tgt == sfrdec_pkg::XRAM_MAP_CONFIG_ADDR) begin
          next_window_en = wval[sfrdec_pkg::WINDOW_EN_BIT];
        end else if (tgt == sfrdec_pkg::XRAM_PAGE_SELECT_ADDR) begin
          next_page = wval[2:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Enable takes its reset from the config value so the two agree
      buffer_window_enable <=
        sfrdec_pkg::XRAM_MAP_CONFIG_RESET[sfrdec_pkg::WINDOW_EN_BIT];
      page_field <= sfrdec_pkg::PAGE_FIELD_RESET;
      dir_rdata <= 8'h00;
      dir_bit_rval <= 1'b0;
      dir_sfr_sel <= 1'b0;
      dir_bit_ok <= 1'b0;
      sfr_byte_addr <= 8'h00;
    end else begin
      buffer_window_enable <= next_window_en;
      page_field <= next_page;
      dir_rdata <= next_rdata;
      dir_bit_rval <= next_bit_rval;
      dir_sfr_sel <= next_sfr_sel;
      dir_bit_ok <= next_bit_ok;
      sfr_byte_addr <= next_byte_addr;
    end
  end

  // External-move routing and wait sequencing
  sfrdec_pkg::sfrdec_state_e state;
  sfrdec_pkg::sfrdec_state_e next_state;
  logic [2:0] wait_cnt;
  logic [2:0] next_wait_cnt;
  logic next_xram_sel;
  logic next_buf_sel;
  logic [9:0] next_xram_addr;
  logic [7:0] next_buf_addr;
  logic next_we_out;
  logic next_ready;
  logic [15:0] eff;
  logic in_window;

  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_xram_sel = xram_sel;
    next_buf_sel = buf_sel;
    next_xram_addr = xram_addr;
    next_buf_addr = buf_addr;
    next_we_out = xmov_we_out;
    next_ready = 1'b0;
    // Short moves borrow the page field as the high address byte
    eff = xmov_short ? {5'h00, page_field, xmov_addr[7:0]}
                     : xmov_addr;
    // Normal RAM at the window addresses is unreachable while enabled
    in_window = buffer_window_enable &&
                eff >= sfrdec_pkg::WINDOW_LO &&
                eff <= sfrdec_pkg::WINDOW_HI;
    case (state)
      sfrdec_pkg::SFRDEC_IDLE: begin
        if (xmov_req) begin
          next_buf_sel = in_window;
          next_xram_sel = !in_window;
          next_xram_addr = eff[sfrdec_pkg::XRAM_ADDR_W-1:0];
          next_buf_addr = eff[7:0];
          next_we_out = xmov_we;
          // Buffer side runs on the usb clock, so allow it to settle
          next_wait_cnt = in_window ? sfrdec_pkg::BUFFER_WAIT_CYCLES
                                    : sfrdec_pkg::XRAM_WAIT_CYCLES;
          next_state = sfrdec_pkg::SFRDEC_WAIT;
        end
      end
      sfrdec_pkg::SFRDEC_WAIT: begin
        // Count is fixed at request time; a later enable change
        // cannot stretch or cut an access already under way
        if (wait_cnt == 3'h1) begin
          next_ready = 1'b1;
          next_state = sfrdec_pkg::SFRDEC_DONE;
        end else begin
          next_wait_cnt = wait_cnt - 3'h1;
        end
      end
      sfrdec_pkg::SFRDEC_DONE: begin
        // Selects stay up through ready so the target sees a full strobe
        next_xram_sel = 1'b0;
        next_buf_sel = 1'b0;
        next_we_out = 1'b0;
        next_state = sfrdec_pkg::SFRDEC_IDLE;
      end
      default: begin
        next_state = sfrdec_pkg::SFRDEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= sfrdec_pkg::SFRDEC_IDLE;
      wait_cnt <= 3'h0;
      xram_sel <= 1'b0;
      buf_sel <= 1'b0;
      xram_addr <= 10'h000;
      buf_addr <= 8'h00;
      xmov_we_out <= 1'b0;
      xmov_ready <= 1'b0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      xram_sel <= next_xram_sel;
      buf_sel <= next_buf_sel;
      xram_addr <= next_xram_addr;
      buf_addr <= next_buf_addr;
      xmov_we_out <= next_we_out;
      xmov_ready <= next_ready;
    end
  end
endmodule // sfrdec_top
`default_nettype wire

// ---- bench/sfrdec_checker_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module sfrdec_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic dir_req,
  input wire logic dir_we,
  input wire logic dir_bit_op,
  input wire logic [7:0] dir_addr,
  input wire logic [7:0] dir_wdata,
  input wire logic [7:0] dir_rdata,
  input wire logic dir_sfr_sel,
  input wire logic dir_bit_ok,
  input wire logic xmov_req,
  input wire logic xmov_short,
  input wire logic [15:0] xmov_addr,
  input wire logic xram_sel,
  input wire logic buf_sel,
  input wire logic xmov_ready,
  input wire logic buffer_window_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Both selects low means the sequencer is idle and takes the request
  sequence s_go;
    xmov_req && !xram_sel && !buf_sel;
  endsequence
  property p_lo; dir_req && !dir_addr[7] |=> !dir_sfr_sel; endproperty
  a_lo: assert property (p_lo) else $error("low hit");
  property p_idle; !dir_req |=> !dir_sfr_sel; endproperty
  a_idle: assert property (p_idle) else $error("idle hit");
  property p_byte;
    dir_req && dir_addr[7] && !dir_bit_op |=> dir_sfr_sel && !dir_bit_ok;
  endproperty
  a_byte: assert property (p_byte) else $error("byte");
  property p_bit; dir_req && dir_addr[7] && dir_bit_op |=> dir_bit_ok;
  endproperty
  a_bit: assert property (p_bit) else $error("bit");
  property p_cfg;
    dir_req && dir_we && !dir_bit_op && dir_addr == 8'h85 && dir_wdata[6]
      |=> buffer_window_enable;
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg write");
  property p_rd; dir_req && !dir_we && !dir_bit_op && dir_addr == 8'h85
    |=> dir_rdata == {1'b0, buffer_window_enable, 6'h03};
  endproperty
  a_rd: assert property (p_rd) else $error("cfg read");
  property p_xram; s_go ##0 !buffer_window_enable
    |=> xram_sel ##1 xmov_ready && xram_sel;
  endproperty
  a_xram: assert property (p_xram) else $error("ram move");
  property p_buf; s_go ##0 buffer_window_enable && !xmov_short &&
    xmov_addr[15:8] == 8'h04 |=> (buf_sel && !xram_sel && !xmov_ready) [*4]
    ##1 xmov_ready;
  endproperty
  a_buf: assert property (p_buf) else $error("buf move");
  c_buf: cover property (xmov_ready && buf_sel);
  c_xram: cover property (xmov_ready && xram_sel);
  c_bit: cover property (dir_bit_ok);
endmodule // sfrdec_checker
bind sfrdec_top sfrdec_checker sfrdec_checker_i (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .dir_req(dir_req),
  .dir_we(dir_we),
  .dir_bit_op(dir_bit_op),
  .dir_addr(dir_addr),
  .dir_wdata(dir_wdata),
  .dir_rdata(dir_rdata),
  .dir_sfr_sel(dir_sfr_sel),
  .dir_bit_ok(dir_bit_ok),
  .xmov_req(xmov_req),
  .xmov_short(xmov_short),
  .xmov_addr(xmov_addr),
  .xram_sel(xram_sel),
  .buf_sel(buf_sel),
  .xmov_ready(xmov_ready),
  .buffer_window_enable(buffer_window_enable)
);
`default_nettype wire

// ---- bench/sfrdec_core.sv ----
`timescale 1ns/1ns
`default_nettype none
module sfrdec_core (
  input wire logic ref_clk,
  input wire logic xmov_ready,
  output logic dir_req,
  output logic dir_we,
  output logic dir_bit_op,
  output logic dir_bit_wval,
  output logic [7:0] dir_addr,
  output logic [7:0] dir_wdata,
  output logic xmov_req,
  output logic xmov_we,
  output logic xmov_short,
  output logic [15:0] xmov_addr
);
  initial begin
    {dir_req, dir_we, dir_bit_op, dir_bit_wval, dir_addr, dir_wdata} = '0;
    {xmov_req, xmov_we, xmov_short, xmov_addr} = '0;
  end
  task automatic dir(logic w, logic b, logic [7:0] a, logic [7:0] v);
    @(posedge ref_clk);
    {dir_req, dir_we, dir_bit_op, dir_bit_wval} <= {1'b1, w, b, v[0]};
    dir_addr <= a;
    dir_wdata <= v;
    @(posedge ref_clk);
    dir_req <= 1'b0;
    // Released bus shows junk, so a stale value never looks held
    dir_addr <= ~a;
    dir_wdata <= ~v;
    #1;
  endtask
  // Buffer moves assume the usb side clock runs at twice the core rate
  task automatic mov(logic w, logic s, logic [15:0] a, output int n);
    repeat (3) @(posedge ref_clk);
    {xmov_req, xmov_we, xmov_short} <= {1'b1, w, s};
    xmov_addr <= a;
    @(posedge ref_clk);
    xmov_req <= 1'b0;
    xmov_addr <= ~a;
    n = 1;
    do begin
      @(posedge ref_clk);
      n++;
      #1;
    end while (!xmov_ready && n < 9);
  endtask
endmodule // sfrdec_core
`default_nettype wire

// ---- bench/sfrdec_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module sfrdec_tb_top;
  logic ref_clk, rst_b, dir_req, dir_we, dir_bit_op, dir_bit_wval, xmov_req;
  logic xmov_we, xmov_short, dir_bit_rval, dir_sfr_sel, dir_bit_ok, xram_sel;
  logic buf_sel, xmov_we_out, xmov_ready, buffer_window_enable;
  logic [7:0] dir_addr, dir_wdata, dir_rdata, sfr_byte_addr, buf_addr;
  logic [15:0] xmov_addr;
  logic [9:0] xram_addr;
  logic [2:0] page_field;
  int n_mismatch = 0;
  int check_count = 0;
  int n;
  sfrdec_top sfrdec_top_i (.*);
  sfrdec_core sfrdec_core_i (.*);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic d(logic w, logic b, logic [7:0] a, logic [7:0] v);
    sfrdec_core_i.dir(w, b, a, v);
  endtask
  task automatic mv(logic s, logic [15:0] a, logic b, logic [15:0] e, int l);
    sfrdec_core_i.mov(a[0], s, a, n);
    chk("sel", {b, !b}, {buf_sel, xram_sel});
    chk("adr", e, b ? buf_addr : xram_addr);
    chk("we", 16'(a[0]), 16'(xmov_we_out));
    chk("lat", 16'(l), 16'(n));
  endtask
  task automatic t_regs;
    d(0, 0, 8'h85, 8'h00);
    chk("cfg", 16'h03, dir_rdata);
    chk("hit", 16'h1, dir_sfr_sel);
    chk("en", 16'h0, buffer_window_enable);
    d(1, 0, 8'h85, 8'hBF);
    d(0, 0, 8'h85, 8'h00);
    chk("cfg", 16'h03, dir_rdata);
    d(1, 0, 8'hAA, 8'hFD);
    d(0, 0, 8'hAA, 8'h00);
    chk("pg", 16'h05, dir_rdata);
    chk("pgf", 16'h5, page_field);
    d(0, 0, 8'h7F, 8'h00);
    chk("lo", 16'h0, dir_sfr_sel);
    d(0, 1, 8'hAE, 8'h00);
    chk("bit", 16'h1A8, {dir_bit_ok, sfr_byte_addr});
    chk("bitv", 16'h0, dir_bit_rval);
  endtask
  task automatic t_move;
    mv(0, 16'h1C05, 0, 16'h005, 2);
    mv(1, 16'hFF33, 0, 16'h133, 2);
    mv(0, 16'h0410, 0, 16'h010, 2);
    d(1, 0, 8'h85, 8'h40);
    chk("en", 16'h1, buffer_window_enable);
    mv(0, 16'h04A7, 1, 16'h0A7, 5);
    mv(0, 16'h0500, 0, 16'h100, 2);
    d(1, 0, 8'hAA, 8'h04);
    mv(1, 16'h00FF, 1, 16'h0FF, 5);
  endtask
  // Reset in mid-run must drop the window and the page again
  task automatic t_reset;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk("rst_en", 16'h0, buffer_window_enable);
    chk("rst_pg", 16'h0, page_field);
    d(0, 0, 8'h85, 8'h00);
    chk("rst_cfg", 16'h03, dir_rdata);
    mv(0, 16'h0410, 0, 16'h010, 2);
  endtask
  initial begin
    rst_b = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs;
    t_move;
    t_reset;
    close_out;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    close_out;
  end
endmodule // sfrdec_tb_top
`default_nettype wire
